// file: pkg/apsc_pkg.sv
package apsc_pkg;

   // ==========================================================
   // Register write port and map
   localparam int ADDR_W = 8;
   localparam int DATA_W = 8;
   localparam logic [ADDR_W-1:0] UNLOCK_ADDR = 8'h11;
   localparam logic [DATA_W-1:0] UNLOCK_KEY = 8'h69;
   localparam logic [ADDR_W-1:0] PWR_CTRL_ADDR = 8'h10;
   localparam int LSLEEP_EN_POS = 0;
   localparam int DEEP_REQ_POS = 1;
   localparam logic LSLEEP_EN_RST = 1'b0;
   localparam logic DEEP_REQ_RST = 1'b0;

   // ==========================================================
   // Timing
   localparam int CLK_MHZ = 40;
   localparam int CONV_TIME_NS = 300;
   localparam int LSLEEP_WKUP_NS = 400;
   localparam int DEEP_PWRUP_US = 250;
   localparam int CONV_CYC = (CONV_TIME_NS * CLK_MHZ + 999) / 1000;
   localparam int LSLEEP_WKUP_CYC = (LSLEEP_WKUP_NS * CLK_MHZ + 999) / 1000;
   localparam int DEEP_PWRUP_CYC = DEEP_PWRUP_US * CLK_MHZ;
   localparam int CNT_W = 16;

   // ==========================================================
   // Types
   typedef enum logic [5:0] {
      ST_ACQUIRE = 6'h01,
      ST_CONVERT = 6'h02,
      ST_LSLEEP = 6'h04,
      ST_WAKE = 6'h08,
      ST_DEEP = 6'h10,
      ST_PWRUP = 6'h20
   } apsc_state_t;

   typedef struct packed {
      logic valid;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] data;
   } apsc_wr_t;

   typedef struct packed {
      logic unlocked;
      logic deep_req;
      logic lsleep_en;
   } apsc_ctrl_t;

   typedef struct packed {
      logic analog_on;
      logic acq_subset_on;
      logic busy;
      logic lsleep;
      logic deep;
      logic powering;
   } apsc_stat_t;

endpackage

// file: logic/apsc_power_ctrl.sv
`timescale 1ns/10ps
// Overview of operation
// (RULE_01) Normal mode keeps every block powered always
// (RULE_02) Light sleep only when its enable bit set
// (RULE_03) Enter light sleep if start high at end
// (RULE_04) Stay asleep while start pin stays high
// (RULE_05) Light sleep powers down acquisition subset
// (RULE_06) Start falling edge begins light-sleep wake-up
// (RULE_07) Host waits wake-up time before next start
// (RULE_08) Conversion time fixed; sleep absorbs slower rates
// (RULE_09) Deep request changes only after unlock key
// (RULE_10) Enter deep sleep on next select rising
// (RULE_11) Deep sleep switches off all analog blocks
// (RULE_12) Registers and port stay alive in deep
// (RULE_13) Host clears request bit to leave deep
// (RULE_14) Ready indicator high once power-up begins
// (RULE_15) Host waits power-up time before converting
// (RULE_16) No conversions in deep or during power-up
module apsc_power_ctrl #(
   parameter int unsigned PWRUP_CYCLES = apsc_pkg::DEEP_PWRUP_CYC
) (
   // Clock and reset
   input wire logic clk_in,
   input wire logic rstn_in,
   // Host pins
   input wire logic conv_start_in,
   input wire logic cs_n_in,
   // Decoded writes from the serial port
   input wire apsc_pkg::apsc_wr_t wr_in,
   // Register contents for read-back
   output apsc_pkg::apsc_ctrl_t ctrl_out,
   // Power and conversion status
   output apsc_pkg::apsc_stat_t stat_out,
   output logic result_valid_out,
   output logic ready_indicator_out
);

   // ==========================================================
   // Elaboration checks
   if (PWRUP_CYCLES < 1 || PWRUP_CYCLES >= (1 << apsc_pkg::CNT_W)) begin : g_chk
      $error("PWRUP_CYCLES out of counter range");
   end

   localparam logic [apsc_pkg::CNT_W-1:0] CONV_LOAD =
      apsc_pkg::CNT_W'(apsc_pkg::CONV_CYC - 1);
   localparam logic [apsc_pkg::CNT_W-1:0] WKUP_LOAD =
      apsc_pkg::CNT_W'(apsc_pkg::LSLEEP_WKUP_CYC - 1);
   localparam logic [apsc_pkg::CNT_W-1:0] PWRUP_LOAD =
      apsc_pkg::CNT_W'(PWRUP_CYCLES - 1);

   function automatic logic cnt_expired(input logic [apsc_pkg::CNT_W-1:0] count);
      return count == '0;
   endfunction

   // ==========================================================
   // Pin edge detection
   logic cs_q_reg, cs_q_next;
   logic st_q_reg, st_q_next;
   logic cs_rise, st_rise;

   always_comb begin
      cs_q_next = cs_n_in;
      st_q_next = conv_start_in;
   end

   always_ff @(posedge clk_in) begin
      if (!rstn_in) begin
         cs_q_reg <= 1'b1;
         st_q_reg <= 1'b0;
      end else begin
         cs_q_reg <= cs_q_next;
         st_q_reg <= st_q_next;
      end
   end

   assign cs_rise = cs_n_in & ~cs_q_reg;
   assign st_rise = conv_start_in & ~st_q_reg;

   // ==========================================================
   // Power-down control register with unlock
   apsc_pkg::apsc_ctrl_t ctrl_reg, ctrl_next;

   // Writes stay live in every state, deep sleep included [RULE_12]
   always_comb begin
      ctrl_next = ctrl_reg;
      if (wr_in.valid) begin
         if (wr_in.addr == apsc_pkg::UNLOCK_ADDR) begin
            ctrl_next.unlocked = (wr_in.data == apsc_pkg::UNLOCK_KEY); // [RULE_09]
         end else if (wr_in.addr == apsc_pkg::PWR_CTRL_ADDR) begin
            ctrl_next.lsleep_en = wr_in.data[apsc_pkg::LSLEEP_EN_POS]; // [RULE_02]
            if (ctrl_reg.unlocked) begin
               ctrl_next.deep_req = wr_in.data[apsc_pkg::DEEP_REQ_POS]; // [RULE_09]
            end
         end
      end
   end

   always_ff @(posedge clk_in) begin
      if (!rstn_in) begin
         ctrl_reg <= '{unlocked: 1'b0,
                       deep_req: apsc_pkg::DEEP_REQ_RST,
                       lsleep_en: apsc_pkg::LSLEEP_EN_RST};
      end else begin
         ctrl_reg <= ctrl_next;
      end
   end

   assign ctrl_out = ctrl_reg;

   // ==========================================================
   // Power state machine
   apsc_pkg::apsc_state_t state_reg, state_next;
   logic [apsc_pkg::CNT_W-1:0] cnt_reg, cnt_next;
   logic pend_reg, pend_next;
   logic rv_reg, rv_next;
   logic rdy_reg, rdy_next;
   apsc_pkg::apsc_stat_t stat_reg, stat_next;
   logic deep_go;

   always_comb begin
      state_next = state_reg;
      cnt_next = cnt_reg;
      rv_next = 1'b0;
      // A select rising edge mid-conversion is held until the result is out
      pend_next = (pend_reg | cs_rise) & ctrl_reg.deep_req; // [RULE_10]
      deep_go = pend_next & (state_reg != apsc_pkg::ST_CONVERT) &
                (state_reg != apsc_pkg::ST_DEEP) &
                (state_reg != apsc_pkg::ST_PWRUP);
      case (state_reg)
         apsc_pkg::ST_ACQUIRE: begin
            if (deep_go) begin
               state_next = apsc_pkg::ST_DEEP; // [RULE_10]
            end else if (st_rise) begin
               state_next = apsc_pkg::ST_CONVERT;
               cnt_next = CONV_LOAD; // [RULE_08]
            end
         end
         apsc_pkg::ST_CONVERT: begin
            if (cnt_expired(cnt_reg)) begin
               rv_next = 1'b1;
               if (ctrl_reg.lsleep_en && conv_start_in) begin
                  state_next = apsc_pkg::ST_LSLEEP; // [RULE_03]
               end else begin
                  state_next = apsc_pkg::ST_ACQUIRE; // [RULE_01]
               end
            end else begin
               cnt_next = cnt_reg - 1'b1; // [RULE_08]
            end
         end
         apsc_pkg::ST_LSLEEP: begin
            if (deep_go) begin
               state_next = apsc_pkg::ST_DEEP;
            end else if (!conv_start_in) begin
               state_next = apsc_pkg::ST_WAKE; // [RULE_06]
               cnt_next = WKUP_LOAD;
            end
         end
         apsc_pkg::ST_WAKE: begin
            // Starts during wake-up are dropped; the host must wait [RULE_07]
            if (deep_go) begin
               state_next = apsc_pkg::ST_DEEP;
            end else if (cnt_expired(cnt_reg)) begin
               state_next = apsc_pkg::ST_ACQUIRE;
            end else begin
               cnt_next = cnt_reg - 1'b1;
            end
         end
         apsc_pkg::ST_DEEP: begin
            if (!ctrl_reg.deep_req) begin
               state_next = apsc_pkg::ST_PWRUP; // [RULE_13]
               cnt_next = PWRUP_LOAD;
            end
         end
         apsc_pkg::ST_PWRUP: begin
            // Starts are ignored until the analog side has settled [RULE_16]
            if (cnt_expired(cnt_reg)) begin
               state_next = apsc_pkg::ST_ACQUIRE; // [RULE_15]
            end else begin
               cnt_next = cnt_reg - 1'b1;
            end
         end
         default: begin
            state_next = apsc_pkg::ST_ACQUIRE;
         end
      endcase
      if (state_next == apsc_pkg::ST_DEEP) begin
         pend_next = 1'b0;
      end
      // Status follows the next state so outputs line up with it
      stat_next.analog_on = (state_next != apsc_pkg::ST_DEEP); // [RULE_11]
      stat_next.acq_subset_on = (state_next != apsc_pkg::ST_DEEP) &&
                                (state_next != apsc_pkg::ST_LSLEEP); // [RULE_05]
      stat_next.busy = (state_next == apsc_pkg::ST_CONVERT);
      stat_next.lsleep = (state_next == apsc_pkg::ST_LSLEEP); // [RULE_04]
      stat_next.deep = (state_next == apsc_pkg::ST_DEEP);
      stat_next.powering = (state_next == apsc_pkg::ST_PWRUP);
      rdy_next = (state_next != apsc_pkg::ST_DEEP); // [RULE_14]
   end

   always_ff @(posedge clk_in) begin
      if (!rstn_in) begin
         state_reg <= apsc_pkg::ST_ACQUIRE;
         cnt_reg <= '0;
         pend_reg <= 1'b0;
         rv_reg <= 1'b0;
         rdy_reg <= 1'b1;
         stat_reg <= '{analog_on: 1'b1, acq_subset_on: 1'b1, default: 1'b0};
      end else begin
         state_reg <= state_next;
         cnt_reg <= cnt_next;
         pend_reg <= pend_next;
         rv_reg <= rv_next;
         rdy_reg <= rdy_next;
         stat_reg <= stat_next;
      end
   end

   assign stat_out = stat_reg;
   assign result_valid_out = rv_reg;
   assign ready_indicator_out = rdy_reg;

   // ==========================================================
   // Assertions
   localparam int CONV_L = apsc_pkg::CONV_CYC - 1;

   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (!rstn_in);

   a_normal_power_on: assert property ( // [RULE_01]
      !stat_out.lsleep && !stat_out.deep |-> stat_out.analog_on && stat_out.acq_subset_on)
      else $error("Blocks powered down outside a sleep mode");

   a_sleep_needs_en: assert property ( // [RULE_02]
      $rose(stat_out.lsleep) |-> $past(ctrl_reg.lsleep_en))
      else $error("Light sleep entered while disabled");

   a_sleep_entry: assert property ( // [RULE_03]
      $fell(stat_out.busy) && $past(ctrl_reg.lsleep_en) && $past(conv_start_in)
      |-> stat_out.lsleep && result_valid_out)
      else $error("Light sleep not entered at end of conversion");

   a_sleep_hold: assert property ( // [RULE_04]
      stat_out.lsleep && conv_start_in && !pend_next |=> stat_out.lsleep)
      else $error("Light sleep left while start held high");

   a_sleep_subset: assert property ( // [RULE_05]
      stat_out.lsleep |-> stat_out.analog_on && !stat_out.acq_subset_on)
      else $error("Wrong blocks powered in light sleep");

   a_wake_start: assert property ( // [RULE_06]
      stat_out.lsleep && !conv_start_in && !pend_next
      |=> state_reg == apsc_pkg::ST_WAKE && !stat_out.lsleep)
      else $error("Falling start edge did not begin wake-up");

   a_conv_fixed: assert property ( // [RULE_08]
      $rose(stat_out.busy) |-> ##CONV_L stat_out.busy ##1 (!stat_out.busy && result_valid_out))
      else $error("Conversion length not fixed");

   a_unlock_guard: assert property ( // [RULE_09]
      !ctrl_reg.unlocked |=> $stable(ctrl_reg.deep_req))
      else $error("Deep request changed while locked");

   a_deep_entry: assert property ( // [RULE_10]
      state_reg == apsc_pkg::ST_ACQUIRE && ctrl_reg.deep_req && cs_rise |=> stat_out.deep)
      else $error("Deep sleep not entered on select rising edge");

   a_deep_analog_off: assert property ( // [RULE_11]
      stat_out.deep |-> !stat_out.analog_on && !ready_indicator_out)
      else $error("Analog blocks on during deep sleep");

   a_deep_regs_kept: assert property ( // [RULE_12]
      stat_out.deep && wr_in.valid && wr_in.addr == apsc_pkg::PWR_CTRL_ADDR
      |=> ctrl_reg.lsleep_en == $past(wr_in.data[apsc_pkg::LSLEEP_EN_POS]))
      else $error("Register write lost in deep sleep");

   a_ready_on_exit: assert property ( // [RULE_14]
      stat_out.deep && !ctrl_reg.deep_req |=> stat_out.powering && ready_indicator_out)
      else $error("Ready indicator not raised on deep exit");

   a_pwrup_no_conv: assert property ( // [RULE_16]
      stat_out.deep || stat_out.powering |=> !stat_out.busy && !result_valid_out)
      else $error("Conversion during deep sleep or power-up");

   a_start_taken: assert property ( // [RULE_01]
      state_reg == apsc_pkg::ST_ACQUIRE && st_rise && !pend_next |=> stat_out.busy)
      else $error("Start edge refused in acquisition");

   a_result_pulse: assert property ( // [RULE_08]
      result_valid_out |=> !result_valid_out)
      else $error("Result strobe longer than one cycle");

   a_no_deep_mid_conv: assert property ( // [RULE_10]
      stat_out.busy |=> !stat_out.deep)
      else $error("Deep sleep entered straight from a conversion");

   a_ready_level: assert property ( // [RULE_14]
      ready_indicator_out == !stat_out.deep)
      else $error("Ready indicator disagrees with deep sleep");

   a_pwrup_ready: assert property ( // [RULE_14]
      stat_out.powering |-> stat_out.analog_on && ready_indicator_out)
      else $error("Ready or analog side low during power-up");

   c_sleep_cycle: cover property (
      $rose(stat_out.lsleep) ##[1:200] state_reg == apsc_pkg::ST_WAKE);
   c_deep_entry: cover property ($rose(stat_out.deep));
   c_pwrup_done: cover property ($fell(stat_out.powering));
   c_normal_conv: cover property ($fell(stat_out.busy) && !stat_out.lsleep);
   c_deep_deferred: cover property (stat_out.busy && pend_reg);

endmodule

// file: sim/apsc_host_model.sv
`timescale 1ns/10ps
module apsc_host_model #(
   parameter int unsigned PWRUP_CYCLES = 20
) (
   // Clock and reset
   input wire logic clk_in,
   input wire logic rstn_in,
   // Device ready pin
   input wire logic ready_in,
   // Host pins and register writes
   output logic conv_start_out,
   output logic cs_n_out,
   output apsc_pkg::apsc_wr_t wr_out
);
   int wake_cnt = 0;
   int pwr_cnt = 0;
   initial begin
      conv_start_out = 1'b0;
      cs_n_out = 1'b1;
      wr_out = '0;
   end
   // ==========================================================
   // Wait timers
   // Host cannot see the state, so it times both waits itself
   always @(posedge clk_in) begin
      if (!rstn_in) begin
         wake_cnt <= 0;
         pwr_cnt <= 0;
      end else begin
         if (conv_start_out)
            wake_cnt <= 0;
         else if (wake_cnt < apsc_pkg::LSLEEP_WKUP_CYC + 2)
            wake_cnt <= wake_cnt + 1;
         if (!ready_in)
            pwr_cnt <= 0;
         else if (pwr_cnt < PWRUP_CYCLES + 2)
            pwr_cnt <= pwr_cnt + 1;
      end
   end
   // ==========================================================
   // Host actions
   task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
      @(posedge clk_in);
      wr_out <= '{valid: 1'b1, addr: addr, data: data};
      @(posedge clk_in);
      wr_out.valid <= 1'b0;
   endtask
   // Unlock precedes every change of the request bit
   task automatic set_deep(input logic on, input logic nap);
      write_reg(apsc_pkg::UNLOCK_ADDR, apsc_pkg::UNLOCK_KEY);
      write_reg(apsc_pkg::PWR_CTRL_ADDR, {6'h00, on, nap});
   endtask
   task automatic pulse_select();
      @(posedge clk_in);
      cs_n_out <= 1'b0;
      @(posedge clk_in);
      cs_n_out <= 1'b1;
   endtask
   // Polite starts wait out wake-up and power-up; rude ones probe refusal
   task automatic start(input logic polite);
      while (polite && (wake_cnt < apsc_pkg::LSLEEP_WKUP_CYC + 2 ||
             pwr_cnt < PWRUP_CYCLES + 2))
         @(posedge clk_in);
      @(posedge clk_in);
      conv_start_out <= 1'b1;
   endtask
   task automatic stop();
      @(posedge clk_in);
      conv_start_out <= 1'b0;
   endtask
endmodule

// file: sim/tb.sv
`timescale 1ns/10ps
module tb;
   localparam int unsigned PWRUP = 20;
   localparam int B_BUSY = 3;
   localparam int B_LSLP = 2;
   localparam int B_DEEP = 1;
   localparam int B_POW = 0;
   logic clk_in = 1'b0;
   logic rstn_in = 1'b0;
   logic conv_start;
   logic cs_n;
   logic result_valid;
   logic ready;
   apsc_pkg::apsc_wr_t wr;
   apsc_pkg::apsc_ctrl_t ctrl;
   apsc_pkg::apsc_stat_t stat;
   int fail_count = 0;
   int comparisons = 0;
   int rv_count = 0;
   int pw_count = 0;
   always #12.5 clk_in = ~clk_in;
   always @(posedge clk_in) begin
      if (result_valid === 1'b1)
         rv_count <= rv_count + 1;
      if (stat.powering === 1'b1)
         pw_count <= pw_count + 1;
   end
   apsc_power_ctrl #(.PWRUP_CYCLES(PWRUP)) apsc_power_ctrl_i (.clk_in(clk_in),
      .rstn_in(rstn_in), .conv_start_in(conv_start), .cs_n_in(cs_n), .wr_in(wr),
      .ctrl_out(ctrl), .stat_out(stat), .result_valid_out(result_valid),
      .ready_indicator_out(ready));
   apsc_host_model #(.PWRUP_CYCLES(PWRUP)) apsc_host_model_i (.clk_in(clk_in),
      .rstn_in(rstn_in), .ready_in(ready), .conv_start_out(conv_start),
      .cs_n_out(cs_n), .wr_out(wr));
   // ==========================================================
   // Helpers
   task automatic tick();
      @(posedge clk_in);
      #1;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      comparisons++;
      if (got !== exp) begin
         fail_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wait_bit(input int sel, input logic val, input int lim, output int n);
      n = 0;
      do begin
         tick();
         n++;
      end while (stat[sel] !== val && n < lim);
   endtask
   task automatic conv_measure();
      int n;
      apsc_host_model_i.start(1'b1);
      wait_bit(B_BUSY, 1'b1, 4, n);
      chk(n <= 3, 1'b1);
      wait_bit(B_BUSY, 1'b0, 40, n);
      chk(n, apsc_pkg::CONV_CYC);
      chk(result_valid, 1'b1);
   endtask
   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   // ==========================================================
   // Scenarios
   task automatic t_reset();
      chk(stat, 6'h30);
      chk(ctrl, 3'h0);
      chk(ready, 1'b1);
   endtask
   task automatic t_normal();
      conv_measure();
      tick();
      chk(stat.lsleep, 1'b0);
      chk(stat[5:4], 2'h3);
      apsc_host_model_i.stop();
   endtask
   task automatic t_lsleep();
      int n;
      apsc_host_model_i.write_reg(apsc_pkg::PWR_CTRL_ADDR, 8'h01);
      tick();
      chk(ctrl, 3'h1);
      conv_measure();
      tick();
      chk(stat.lsleep, 1'b1);
      chk(stat.acq_subset_on, 1'b0);
      repeat (30) tick();
      chk(stat.lsleep, 1'b1);
      apsc_host_model_i.stop();
      wait_bit(B_LSLP, 1'b0, 4, n);
      chk(n <= 3, 1'b1);
      conv_measure();
      apsc_host_model_i.stop();
      apsc_host_model_i.write_reg(apsc_pkg::PWR_CTRL_ADDR, 8'h00);
   endtask
   task automatic t_deep();
      int n;
      int rv_before;
      // Locked write must leave the request bit clear
      apsc_host_model_i.write_reg(apsc_pkg::PWR_CTRL_ADDR, 8'h02);
      tick();
      chk(ctrl, 3'h0);
      apsc_host_model_i.set_deep(1'b1, 1'b0);
      tick();
      chk(ctrl, 3'h6);
      chk(stat.deep, 1'b0);
      apsc_host_model_i.pulse_select();
      wait_bit(B_DEEP, 1'b1, 4, n);
      chk(n <= 3, 1'b1);
      chk(stat.analog_on, 1'b0);
      chk(ready, 1'b0);
      apsc_host_model_i.write_reg(apsc_pkg::PWR_CTRL_ADDR, 8'h03);
      tick();
      chk(ctrl, 3'h7);
      chk(stat.deep, 1'b1);
      rv_before = rv_count;
      apsc_host_model_i.start(1'b0);
      wait_bit(B_BUSY, 1'b1, 15, n);
      chk(n, 8'h0f);
      apsc_host_model_i.stop();
      apsc_host_model_i.write_reg(apsc_pkg::PWR_CTRL_ADDR, 8'h00);
      wait_bit(B_POW, 1'b1, 4, n);
      chk(n, 8'h01);
      chk(ready, 1'b1);
      chk(stat.deep, 1'b0);
      // Early start lands inside power-up and must be dropped
      apsc_host_model_i.start(1'b0);
      apsc_host_model_i.stop();
      wait_bit(B_POW, 1'b0, 60, n);
      chk(pw_count, PWRUP);
      chk(rv_count - rv_before, 8'h00);
      conv_measure();
      apsc_host_model_i.stop();
   endtask
   task automatic t_defer();
      int n;
      // Light sleep armed, but start released before the conversion ends
      apsc_host_model_i.write_reg(apsc_pkg::PWR_CTRL_ADDR, 8'h01);
      apsc_host_model_i.start(1'b1);
      apsc_host_model_i.stop();
      wait_bit(B_BUSY, 1'b0, 40, n);
      chk(n, apsc_pkg::CONV_CYC);
      chk(result_valid, 1'b1);
      chk(stat.lsleep, 1'b0);
      chk(stat.acq_subset_on, 1'b1);
      // Select edge mid-conversion defers deep entry to the conversion end
      apsc_host_model_i.set_deep(1'b1, 1'b0);
      apsc_host_model_i.start(1'b1);
      apsc_host_model_i.pulse_select();
      tick();
      chk(stat.busy, 1'b1);
      chk(stat.deep, 1'b0);
      wait_bit(B_BUSY, 1'b0, 40, n);
      chk(result_valid, 1'b1);
      chk(stat.deep, 1'b0);
      tick();
      chk(stat.deep, 1'b1);
      apsc_host_model_i.stop();
      apsc_host_model_i.write_reg(apsc_pkg::PWR_CTRL_ADDR, 8'h00);
      wait_bit(B_POW, 1'b1, 4, n);
      chk(n, 8'h01);
      chk(ready, 1'b1);
      wait_bit(B_POW, 1'b0, 60, n);
      chk(n, PWRUP);
      // A wrong key relocks the request bit
      apsc_host_model_i.write_reg(apsc_pkg::UNLOCK_ADDR, 8'h00);
      apsc_host_model_i.write_reg(apsc_pkg::PWR_CTRL_ADDR, 8'h02);
      tick();
      chk(ctrl, 3'h0);
   endtask
   // ==========================================================
   // Main sequence and watchdog
   initial begin
      repeat (20) @(posedge clk_in);
      rstn_in <= 1'b1;
      tick();
      t_reset();
      t_normal();
      t_lsleep();
      t_deep();
      t_defer();
      give_verdict();
   end
   initial begin
      #100000;
      fail_count++;
      give_verdict();
   end
endmodule
